// File: bench/scp_host_model.sv
// host model driving the counter programming pins
`timescale 1ns/10ps
module scp_host_model (
    input wire logic sys_clk_i, // strobe timing reference
    output logic ser_clk_o, // serial clock, still outside frames once the reset-time pulses are done
    output logic ser_data_o, // serial data
    output logic ser_load_o, // serial load strobe
    output logic hop_wr_o, // hop strobe
    output logic enh_wr_o, // enhancement enable or strobe
    output logic main_low_strobe_o, // main low write
    output logic main_high_strobe_o, // main high write
    output logic swallow_wr_o, // swallow write
    output logic [7:0] par_data_o, // parallel bus or direct pins
    output logic [3:0] ref_pin_o, // direct reference pins
    output logic [3:0] swallow_pin_o, // direct swallow pins
    output logic bypass_mode_o, // direct mode select
    output logic serial_mode_o, // serial or parallel select
    output logic serial_bank_select_o, // serial bank select
    output logic parallel_bank_select_o // parallel bank select
);
    logic [4:0] stb;
    assign {hop_wr_o, enh_wr_o, main_high_strobe_o, swallow_wr_o, main_low_strobe_o} = stb;
    initial begin
        {ser_clk_o, ser_data_o, stb} = 7'h00;
        ser_load_o = 1'b1;
        {par_data_o, ref_pin_o, swallow_pin_o} = 16'h0000;
        {bypass_mode_o, serial_mode_o, serial_bank_select_o, parallel_bank_select_o} = 4'b0111;
    end
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    // data changes only while the serial clock is low
    task automatic shift(input logic [19:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            ser_data_o <= v[i];
            #6 ser_clk_o = 1'b1;
            #6 ser_clk_o = 1'b0;
        end
        ser_data_o <= ~v[0];
    endtask
    task automatic ser_word(input logic [19:0] w);
        @(posedge sys_clk_i);
        ser_load_o <= 1'b0;
        stb[3] <= 1'b0;
        idle(6);
        shift(w, 20);
        idle(4);
        ser_load_o <= 1'b1;
        idle(12);
    endtask
    task automatic ser_enh(input logic [7:0] e);
        @(posedge sys_clk_i);
        ser_load_o <= 1'b0;
        stb[3] <= 1'b1;
        idle(6);
        shift({12'h000, e}, 8);
        idle(4);
        stb[3] <= 1'b0;
        idle(8);
        ser_load_o <= 1'b1;
        idle(12);
    endtask
    // 0 main low, 1 swallow, 2 main high, 3 enhancement, 4 hop
    task automatic strobe(input int which, input logic [7:0] d);
        @(posedge sys_clk_i);
        par_data_o <= d;
        idle(5);
        stb[which] <= 1'b1;
        idle(5);
        stb[which] <= 1'b0;
        idle(12);
    endtask
    task automatic mode(input logic bm, input logic sm, input logic fs, input logic fp);
        @(posedge sys_clk_i);
        bypass_mode_o <= bm;
        serial_mode_o <= sm;
        serial_bank_select_o <= fs;
        parallel_bank_select_o <= fp;
        idle(12);
    endtask
    task automatic direct(input logic [3:0] r, input logic [7:0] d, input logic [3:0] a);
        @(posedge sys_clk_i);
        ref_pin_o <= r;
        par_data_o <= d;
        swallow_pin_o <= a;
        idle(12);
    endtask
endmodule

// File: bench/test_synth_counter_programming_port.sv
// self-checking bench for the counter programming port
`timescale 1ns/10ps
module test_synth_counter_programming_port;
    import scp_pkg::*;
    logic sys_clk_i, rst_n_i, ser_clk_i, ser_data_i, ser_load_i, hop_wr_i, enh_wr_i;
    logic main_low_strobe_i, main_high_strobe_i, swallow_wr_i, bypass_mode_i, serial_mode_i;
    logic serial_bank_select_i, parallel_bank_select_i, modulus_sel_i, hsel_i, hwrite_i;
    logic hreadyout_o, hresp_o, presc_en_n_o, presc_bypass_o;
    logic [7:0] par_data_i, enh_o;
    logic [3:0] ref_pin_i, swallow_pin_i, presc_ratio_o;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, junk;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i;
    logic [R_W-1:0] ref_cnt_o;
    logic [M_W-1:0] main_cnt_o;
    logic [A_W-1:0] swallow_cnt_o;
    int mismatches = 0;
    int cmp_count = 0;
    localparam logic [19:0] W1 = {1'b1, 9'h1A5, 6'h2B, 4'h7};
    localparam logic [19:0] W2 = {1'b0, 9'h0CE, 6'h1D, 4'hE};
    scp_top scp_top_i (.sys_clk_i, .rst_n_i, .ser_clk_i, .ser_data_i, .ser_load_i, .hop_wr_i, .enh_wr_i,
        .main_low_strobe_i, .main_high_strobe_i, .swallow_wr_i, .par_data_i, .ref_pin_i, .swallow_pin_i,
        .bypass_mode_i, .serial_mode_i, .serial_bank_select_i, .parallel_bank_select_i, .modulus_sel_i,
        .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
        .hreadyout_o, .hresp_o, .ref_cnt_o, .main_cnt_o, .swallow_cnt_o, .presc_en_n_o, .presc_bypass_o,
        .presc_ratio_o, .enh_o);
    scp_host_model scp_host_model_i (.sys_clk_i, .ser_clk_o(ser_clk_i), .ser_data_o(ser_data_i),
        .ser_load_o(ser_load_i), .hop_wr_o(hop_wr_i), .enh_wr_o(enh_wr_i), .main_low_strobe_o(main_low_strobe_i),
        .main_high_strobe_o(main_high_strobe_i), .swallow_wr_o(swallow_wr_i), .par_data_o(par_data_i),
        .ref_pin_o(ref_pin_i), .swallow_pin_o(swallow_pin_i), .bypass_mode_o(bypass_mode_i),
        .serial_mode_o(serial_mode_i), .serial_bank_select_o(serial_bank_select_i),
        .parallel_bank_select_o(parallel_bank_select_i));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one single ahb transfer; waits on hready in both phases
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge sys_clk_i);
        hsel_i <= 1'b1;
        haddr_i <= {24'h00_0000, a};
        hwrite_i <= wr;
        htrans_i <= 2'b10;
        @(posedge sys_clk_i);
        while (hreadyout_o !== 1'b1) @(posedge sys_clk_i);
        htrans_i <= 2'b00;
        hwdata_i <= wd;
        @(posedge sys_clk_i);
        while (hreadyout_o !== 1'b1) @(posedge sys_clk_i);
        rd = hrdata_o;
        hsel_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        ahb(1'b0, a, 32'h0000_0000, d);
        chk(what, d, exp);
        chk("response", hresp_o, 32'h0000_0000);
    endtask
    task automatic chk_cnt(input logic [19:0] w);
        chk("reference", ref_cnt_o, w[R_LSB+:R_W]);
        chk("main", main_cnt_o, w[M_LSB+:M_W]);
        chk("swallow", swallow_cnt_o, w[A_LSB+:A_W]);
        chk("prescaler enable", presc_en_n_o, w[PRE_POS]);
        chk("bypass", presc_bypass_o, w[PRE_POS]);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk_cnt(20'h0_0000);
        chk("ratio", presc_ratio_o, RATIO_LO);
        chk("enhancement", enh_o, 32'h0000_0000);
        ahb(1'b1, 8'h20, 32'hFFFF_FFFF, junk);
        rd(8'h20, 32'h0000_0000, "unmapped");
        ahb(1'b1, OFS_PRIM, 32'h000F_FFFF, junk);
        rd(OFS_PRIM, 32'h0000_0000, "primary read only");
        ahb(1'b1, OFS_CTRL, 32'h0000_0001, junk);
        rd(OFS_CTRL, 32'h0000_0001, "control");
        ahb(1'b1, OFS_CTRL, 32'h0000_0000, junk);
        rd(OFS_CTRL, 32'h0000_0000, "control");
    endtask
    task automatic t_serial();
        scp_host_model_i.ser_word(W1);
        chk_cnt(W1);
        rd(OFS_PRIM, W1, "primary");
        rd(OFS_SEC, W1, "secondary");
        rd(OFS_ACT, W1, "active");
        scp_host_model_i.ser_enh(8'hC3);
        chk("enhancement", enh_o, 32'h0000_00C3);
        rd(OFS_PRIM, W1, "primary kept");
        rd(OFS_STAT, 32'h0000_04C3, "status");
    endtask
    task automatic t_parallel();
        scp_host_model_i.mode(1'b0, 1'b0, 1'b1, 1'b1);
        scp_host_model_i.strobe(3, 8'h5A);
        chk("enhancement", enh_o, 32'h0000_005A);
        scp_host_model_i.strobe(0, {W2[PRE_POS], W2[M_LSB+:7]});
        scp_host_model_i.strobe(1, W2[7:0]);
        scp_host_model_i.strobe(2, {4'h0, W2[9:8], W2[18:17]});
        chk_cnt(W2);
        @(posedge sys_clk_i);
        modulus_sel_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        chk("ratio", presc_ratio_o, RATIO_HI);
        modulus_sel_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        chk("ratio", presc_ratio_o, RATIO_LO);
        scp_host_model_i.mode(1'b0, 1'b0, 1'b1, 1'b0);
        chk_cnt(W1);
        scp_host_model_i.mode(1'b0, 1'b1, 1'b0, 1'b0);
        chk_cnt(W1);
        scp_host_model_i.mode(1'b0, 1'b0, 1'b1, 1'b0);
        scp_host_model_i.strobe(4, 8'h00);
        chk_cnt(W2);
        rd(OFS_SEC, W2, "secondary");
    endtask
    task automatic t_direct();
        scp_host_model_i.mode(1'b1, 1'b0, 1'b1, 1'b1);
        scp_host_model_i.direct(4'h9, 8'hB5, 4'h6);
        chk_cnt({1'b1, 2'b00, 7'h35, 2'b00, 4'h9, 4'h6});
        rd(OFS_STAT, 32'h0000_085A, "status");
        scp_host_model_i.direct(4'h3, 8'h4A, 4'hC);
        chk_cnt({1'b0, 2'b00, 7'h4A, 2'b00, 4'h3, 4'hC});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        #50000;
        mismatches++;
        give_verdict();
    end
    initial begin
        {rst_n_i, hsel_i, hwrite_i, modulus_sel_i} = 4'h0;
        {haddr_i, hwdata_i, htrans_i} = 66'h0;
        hsize_i = 3'b010;
        // the link side clears only while its clock runs
        fork
            repeat (3) @(posedge sys_clk_i);
            scp_host_model_i.shift(20'h0_0000, 4);
        join
        @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        // the link side leaves reset only on its own clock edges
        scp_host_model_i.shift(20'h0_0000, 4);
        repeat (12) @(posedge sys_clk_i);
        t_reset();
        t_serial();
        t_parallel();
        t_direct();
        give_verdict();
    end
endmodule

// File: design/scp_pkg.sv
// constants for the synthesizer counter programming port
package scp_pkg;
    // primary word layout: {pre_en, m[8:0], r[5:0], a[3:0]}
    localparam int PRIM_W = 20;
    localparam int ENH_W = 8;
    localparam int A_LSB = 0;
    localparam int R_LSB = 4;
    localparam int M_LSB = 10;
    localparam int PRE_POS = 19;
    localparam int A_W = 4;
    localparam int R_W = 6;
    localparam int M_W = 9;
    localparam logic [PRIM_W-1:0] PRIM_RST = 20'h0_0000;
    localparam logic [ENH_W-1:0] ENH_RST = 8'h00;
    // synchronised pin vector positions
    localparam int P_D0 = 0;
    localparam int P_RD0 = 8;
    localparam int P_AD0 = 12;
    localparam int P_SWR = 16;
    localparam int P_HOP = 17;
    localparam int P_EWR = 18;
    localparam int P_MLO = 19;
    localparam int P_MHI = 20;
    localparam int P_AWR = 21;
    localparam int P_BM = 22;
    localparam int P_SM = 23;
    localparam int P_FS = 24;
    localparam int P_FP = 25;
    localparam int PIN_W = 26;
    // register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PRIM = 8'h04;
    localparam logic [7:0] OFS_SEC = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_ACT = 8'h10;
    localparam logic [3:0] RATIO_LO = 4'hA;
    localparam logic [3:0] RATIO_HI = 4'hB;
    typedef enum logic [1:0] {
        SCP_MODE_PAR = 2'b00,
        SCP_MODE_SER = 2'b01,
        SCP_MODE_DIR = 2'b10
    } scp_mode_t;
endpackage

// File: design/scp_top.sv
// counter programming port: serial, parallel and direct loading of r, m, a counters
//
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/10ps
module scp_top
    import scp_pkg::*;
(
    input wire logic sys_clk_i, // 200 MHz system clock
    input wire logic rst_n_i, // synchronous reset, active low
    input wire logic ser_clk_i, // serial shift clock from host
    input wire logic ser_data_i, // serial data, msb first
    input wire logic ser_load_i, // serial load strobe
    input wire logic hop_wr_i, // hop write strobe
    input wire logic enh_wr_i, // enhancement write enable/strobe
    input wire logic main_low_strobe_i, // parallel main low write
    input wire logic main_high_strobe_i, // parallel main high write
    input wire logic swallow_wr_i, // parallel swallow write
    input wire logic [7:0] par_data_i, // parallel bus / direct m and pre_en
    input wire logic [3:0] ref_pin_i, // direct reference bits 3..0
    input wire logic [3:0] swallow_pin_i, // direct swallow bits 3..0
    input wire logic bypass_mode_i, // 1 selects direct mode
    input wire logic serial_mode_i, // 1 serial, 0 parallel
    input wire logic serial_bank_select_i, // serial bank select
    input wire logic parallel_bank_select_i, // parallel bank select
    input wire logic modulus_sel_i, // from counter logic: 1 divides by 11
    input wire logic hsel_i, // ahb select
    input wire logic [31:0] haddr_i, // ahb address
    input wire logic [1:0] htrans_i, // ahb transfer type
    input wire logic hwrite_i, // ahb write
    input wire logic [2:0] hsize_i, // ahb size
    input wire logic [31:0] hwdata_i, // ahb write data
    input wire logic hready_i, // ahb bus ready
    output logic [31:0] hrdata_o, // ahb read data
    output logic hreadyout_o, // ahb slave ready
    output logic hresp_o, // ahb response, always okay
    output logic [R_W-1:0] ref_cnt_o, // reference counter value
    output logic [M_W-1:0] main_cnt_o, // main counter value
    output logic [A_W-1:0] swallow_cnt_o, // swallow counter value
    output logic presc_en_n_o, // prescaler enable, active low
    output logic presc_bypass_o, // input routed past prescaler
    output logic [3:0] presc_ratio_o, // prescaler ratio now in use
    output logic [ENH_W-1:0] enh_o // enhancement register
);

////////////////////////////////////////////////////////////////////////////////
// link domain: serial shift registers

logic lrst_s1_r;
logic lrst_s2_r;
logic [PRIM_W-1:0] ser_sr_r;
logic [ENH_W-1:0] enh_sr_r;

always_ff @(posedge ser_clk_i) begin
    lrst_s1_r <= rst_n_i;
    lrst_s2_r <= lrst_s1_r;
end

// neither shift register looks at the load strobe: ser_sr_r shifts while enh_wr_i is low and
// enh_sr_r while it is high; the system domain copies ser_sr_r after the synchronised load strobe rises and enh_sr_r after enh_wr_i falls
always_ff @(posedge ser_clk_i) begin
    if (!lrst_s2_r) begin
        ser_sr_r <= PRIM_RST;
    end else if (!enh_wr_i) begin
        ser_sr_r <= {ser_sr_r[PRIM_W-2:0], ser_data_i};
    end
end

always_ff @(posedge ser_clk_i) begin
    if (!lrst_s2_r) begin
        enh_sr_r <= ENH_RST;
    end else if (enh_wr_i) begin
        enh_sr_r <= {enh_sr_r[ENH_W-2:0], ser_data_i};
    end
end

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers: three flops, change taken when second and third agree

logic [PIN_W-1:0] pin_raw;
logic [PIN_W-1:0] pin_f;
logic [PIN_W-1:0] pin_p_r;
logic [PIN_W-1:0] pin_rise;
logic [PIN_W-1:0] pin_fall;

assign pin_raw = {parallel_bank_select_i, serial_bank_select_i, serial_mode_i, bypass_mode_i,
                  swallow_wr_i, main_high_strobe_i, main_low_strobe_i, enh_wr_i, hop_wr_i,
                  ser_load_i, swallow_pin_i, ref_pin_i, par_data_i};

genvar gi;
for (gi = 0; gi < PIN_W; gi++) begin : g_sync
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic f_r;
    // in reset the chain fills with the pin level, so no false edge follows release
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            s1_r <= pin_raw[gi];
            s2_r <= s1_r;
            s3_r <= s2_r;
            f_r <= s3_r;
        end else begin
            s1_r <= pin_raw[gi];
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                f_r <= s3_r;
            end
        end
    end
    assign pin_f[gi] = f_r;
end

always_ff @(posedge sys_clk_i) begin
    pin_p_r <= pin_f;
end

assign pin_rise = pin_f & ~pin_p_r;
assign pin_fall = ~pin_f & pin_p_r;

////////////////////////////////////////////////////////////////////////////////
// mode decode

scp_mode_t mode;
logic ser_m;
logic par_m;
logic [7:0] pd;

always_comb begin
    if (pin_f[P_BM]) begin
        mode = SCP_MODE_DIR;
    end else if (pin_f[P_SM]) begin
        mode = SCP_MODE_SER;
    end else begin
        mode = SCP_MODE_PAR;
    end
end

assign ser_m = (mode == SCP_MODE_SER);
assign par_m = (mode == SCP_MODE_PAR);
assign pd = pin_f[P_D0 +: 8];

////////////////////////////////////////////////////////////////////////////////
// primary, secondary and enhancement registers

logic [PRIM_W-1:0] prim_r;
logic [PRIM_W-1:0] prim_nxt;
logic [PRIM_W-1:0] sec_r;
logic [ENH_W-1:0] enh_r;
logic ser_load;

assign ser_load = ser_m && pin_rise[P_SWR];

always_comb begin
    prim_nxt = prim_r;
    if (ser_load) begin
        prim_nxt = ser_sr_r;
    end
    if (par_m && pin_rise[P_MLO]) begin
        prim_nxt[PRE_POS] = pd[7];
        prim_nxt[M_LSB +: 7] = pd[6:0];
    end
    if (par_m && pin_rise[P_AWR]) begin
        prim_nxt[R_LSB +: 4] = pd[7:4];
        prim_nxt[A_LSB +: 4] = pd[3:0];
    end
    if (par_m && pin_rise[P_MHI]) begin
        prim_nxt[R_LSB+4 +: 2] = pd[3:2];
        prim_nxt[M_LSB+7 +: 2] = pd[1:0];
    end
end

always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
        prim_r <= PRIM_RST;
    end else begin
        prim_r <= prim_nxt;
    end
end

// a serial load passes the freshly shifted word on to the secondary bank
always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
        sec_r <= PRIM_RST;
    end else if (ser_load) begin
        sec_r <= ser_sr_r;
    end else if (!pin_f[P_BM] && pin_rise[P_HOP]) begin
        sec_r <= prim_r;
    end
end

always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
        enh_r <= ENH_RST;
    end else if (par_m && pin_rise[P_EWR]) begin
        enh_r <= pd;
    end else if (ser_m && pin_fall[P_EWR]) begin
        enh_r <= enh_sr_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// ahb-lite slave

logic hold_r;
logic wr_pend_r;
logic [7:0] wr_addr_r;
logic addr_ok;
logic [31:0] rd_val;
logic [PRIM_W-1:0] bank;
logic [PRIM_W-1:0] act;

assign addr_ok = hsel_i && hready_i && htrans_i[1];

always_comb begin
    case (haddr_i[7:0])
        OFS_CTRL: rd_val = {31'h0000_0000, hold_r};
        OFS_PRIM: rd_val = {12'h000, prim_r};
        OFS_SEC: rd_val = {12'h000, sec_r};
        OFS_STAT: rd_val = {20'h0_0000, 2'(mode), 2'b00, enh_r};
        OFS_ACT: rd_val = {12'h000, act};
        default: rd_val = 32'h0000_0000;
    endcase
end

always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
        wr_pend_r <= 1'b0;
        wr_addr_r <= 8'h00;
        hrdata_o <= 32'h0000_0000;
        hreadyout_o <= 1'b0;
        hresp_o <= 1'b0;
    end else begin
        wr_pend_r <= addr_ok && hwrite_i;
        wr_addr_r <= haddr_i[7:0];
        hreadyout_o <= 1'b1;
        hresp_o <= 1'b0;
        if (addr_ok && !hwrite_i) begin
            hrdata_o <= (|haddr_i[31:8]) ? 32'h0000_0000 : rd_val;
        end
    end
end

always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
        hold_r <= 1'b0;
    end else if (wr_pend_r && wr_addr_r == OFS_CTRL) begin
        hold_r <= hwdata_i[0];
    end
end

////////////////////////////////////////////////////////////////////////////////
// counter programming outputs

always_comb begin
    if (ser_m) begin
        bank = pin_f[P_FS] ? prim_r : sec_r;
    end else begin
        bank = pin_f[P_FP] ? prim_r : sec_r;
    end
    act = bank;
    if (mode == SCP_MODE_DIR) begin
        act = PRIM_RST;
        act[R_LSB +: 4] = pin_f[P_RD0 +: 4];
        act[M_LSB +: 7] = pd[6:0];
        act[PRE_POS] = pd[7];
        act[A_LSB +: 4] = pin_f[P_AD0 +: 4];
    end
end

always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
        ref_cnt_o <= '0;
        main_cnt_o <= '0;
        swallow_cnt_o <= '0;
        presc_en_n_o <= 1'b0;
        presc_bypass_o <= 1'b0;
        enh_o <= ENH_RST;
    end else begin
        enh_o <= enh_r;
        if (!hold_r) begin
            ref_cnt_o <= act[R_LSB +: R_W];
            main_cnt_o <= act[M_LSB +: M_W];
            swallow_cnt_o <= act[A_LSB +: A_W];
            presc_en_n_o <= act[PRE_POS];
            presc_bypass_o <= act[PRE_POS];
        end
    end
end

always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
        presc_ratio_o <= RATIO_LO;
    end else begin
        presc_ratio_o <= modulus_sel_i ? RATIO_HI : RATIO_LO;
    end
end

////////////////////////////////////////////////////////////////////////////////
// assertions

a_serial_shift: assert property (@(posedge ser_clk_i) disable iff (!lrst_s2_r)
    !enh_wr_i |=> ser_sr_r == {$past(ser_sr_r[PRIM_W-2:0]), $past(ser_data_i)})
    else $error("primary shift wrong");
a_enh_shift: assert property (@(posedge ser_clk_i) disable iff (!lrst_s2_r)
    enh_wr_i |=> enh_sr_r == {$past(enh_sr_r[ENH_W-2:0]), $past(ser_data_i)} && $stable(ser_sr_r))
    else $error("enhancement shift wrong");
a_hop_copy: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (pin_rise[P_HOP] && !pin_f[P_BM] && !ser_load) |=> sec_r == $past(prim_r))
    else $error("hop copy missed");
a_serial_load: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ser_load |=> prim_r == $past(ser_sr_r) && sec_r == prim_r)
    else $error("serial load missed");
a_main_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (par_m && pin_rise[P_MLO]) |=> {prim_r[PRE_POS], prim_r[M_LSB +: 7]} == $past(pd))
    else $error("main low write wrong");
a_swallow_wr: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (par_m && pin_rise[P_AWR]) |=> {prim_r[R_LSB +: 4], prim_r[A_LSB +: 4]} == $past(pd))
    else $error("swallow write wrong");
a_main_high: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (par_m && pin_rise[P_MHI]) |=> {prim_r[R_LSB+4 +: 2], prim_r[M_LSB+7 +: 2]} == $past(pd[3:0]))
    else $error("main high write wrong");
a_enh_par: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (par_m && pin_rise[P_EWR]) |=> ##1 enh_o == $past(pd, 2))
    else $error("enhancement capture wrong");
a_bank_serial: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ser_m && !hold_r) |=> main_cnt_o == $past(pin_f[P_FS] ? prim_r[M_LSB +: M_W] : sec_r[M_LSB +: M_W]))
    else $error("serial bank select wrong");
a_bank_par: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (par_m && !hold_r) |=> ref_cnt_o == $past(pin_f[P_FP] ? prim_r[R_LSB +: R_W] : sec_r[R_LSB +: R_W]))
    else $error("parallel bank select wrong");
a_direct_pins: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (pin_f[P_BM] && !hold_r) |=> ref_cnt_o == {2'b00, $past(pin_f[P_RD0 +: 4])}
    && main_cnt_o == {2'b00, $past(pd[6:0])})
    else $error("direct pins not followed");
a_presc_bypass: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    presc_bypass_o == presc_en_n_o)
    else $error("bypass not tied to enable level");
a_presc_ratio: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    modulus_sel_i |=> presc_ratio_o == RATIO_HI)
    else $error("ratio not eleven");

c_serial_load: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) ser_load);
c_hop: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) pin_rise[P_HOP] && par_m);
c_par_writes: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    par_m && pin_rise[P_MLO] ##[1:200] pin_rise[P_MHI]);
c_direct: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) mode == SCP_MODE_DIR);

endmodule
